// ===== rtl/loop_detector_channel_status.sv
// Two-channel inductive loop detector: scanning, tuning, faults, calls, bus.
// Assumes a measurement counter on mclk and switches/pins that need syncing.
// Contract
// - External active-low reset pin resets the detector
// - Any switch change resets the detector
// - Each channel tunes itself after reset
// - Reference tracks slow drift continuously; here only in the run state while no vehicle is detected
// - Only one loop oscillator energized at once
// - Flag open, short, over-25% inductance change
// - Faulted channel holds its output in call
// - Faulted channel flashes both lamps, then pauses
// - Flash count per second encodes fault type
// - Cleared fault restores detect lamp and output
// - Fault lamp keeps last fault code shown
// - Change fault accepts new reference after 2s
// - Detect lamp solid while channel calls
// - Each channel drives its own status output
// - Status low normally, high on supply fail
// - Status off pulse 50/100/150 ms, then 50 on
// - Status pulse widths within plus minus 10ms
// - Pulse mode: occupied loop re-baselines after 2s
// - Response time follows sensitivity setting
// - Sensitivity zero switches the channel off
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "loop_detector_regs.svh"
module loop_detector_channel_status #(
  parameter int TICK_CYCLES = `LD_TICK_NS / `LD_CLK_PERIOD_NS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic extResetPinN,
  input wire logic supplyFailPin,
  input wire logic [1:0] loopOpenPin,
  input wire logic [1:0] loopShortPin,
  input wire logic [7:0] sensSwitchPin,
  input wire logic [3:0] modeSwitchPin,
  input wire logic [3:0] freqSwitchPin,
  input wire logic [`LD_MEAS_W-1:0] measCount,
  input wire logic measValid,
  output logic [1:0] oscEnable,
  output logic [3:0] loopFreqSel,
  output logic [1:0] callOut,
  output logic [1:0] vehicleDetectLamp,
  output logic [1:0] loopFaultLamp,
  output logic [1:0] statusOut
);
  import loop_detector_pkg::*;

  localparam int PW = 22;
  localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

  logic [PW-1:0] syncA_reg;
  logic [PW-1:0] syncB_reg;
  logic [15:0] switchPrev_reg;
  logic [16:0] tickCnt_reg;
  logic msTick;
  logic fullReset;
  logic swReset_reg;
  logic clrMem_reg;
  logic extResetN;
  logic supplyFail;
  logic [1:0] loopOpen;
  logic [1:0] loopShort;
  logic [15:0] switchNow;
  logic [3:0] sens [2];
  logic [1:0] mode [2];
  scan_state_t scan_reg;
  logic [11:0] slotMs_reg;
  logic [1:0] sampleHit;
  logic [1:0] slotTimeout;
  chan_state_t chanState_reg [2];
  logic [`LD_MEAS_W-1:0] ref_reg [2];
  logic [`LD_MEAS_W-1:0] lastMeas_reg [2];
  fault_t faultCode_reg [2];
  fault_t faultMem_reg [2];
  logic [11:0] holdMs_reg [2];
  logic [11:0] trackMs_reg [2];
  logic [1:0] detLevel_reg;
  logic [11:0] confirmMs_reg [2];
  logic [1:0] callLevel_reg;
  logic [1:0] callPrev_reg;
  logic [11:0] pulseMs_reg [2];
  logic [11:0] inhibitMs_reg [2];
  logic [1:0] rebase;
  logic [1:0] faultActive;

  function automatic logic [`LD_MEAS_W-1:0] absDiff(input logic [`LD_MEAS_W-1:0] a,
                                                   input logic [`LD_MEAS_W-1:0] b);
    absDiff = (a > b) ? a - b : b - a;
  endfunction

  // Higher sensitivity means a smaller fraction of the reference
  function automatic logic [`LD_MEAS_W-1:0] threshold(input logic [`LD_MEAS_W-1:0] r,
                                                     input logic [3:0] s);
    logic [4:0] sh;
    sh = 5'd5 + 5'(({1'b0, s} + 5'd1) >> 1);
    threshold = r >> sh;
  endfunction

  function automatic logic [11:0] respMs(input logic [3:0] s);
    case (s)
      4'hF: respMs = 12'd76;
      4'hE: respMs = 12'd57;
      4'hD: respMs = 12'd38;
      4'hC: respMs = 12'd26;
      4'hB: respMs = 12'd18;
      4'hA: respMs = 12'd13;
      4'h9: respMs = 12'd9;
      4'h8: respMs = 12'd7;
      4'h7: respMs = 12'd5;
      4'h6: respMs = 12'd5;
      default: respMs = 12'd4;
    endcase
  endfunction

  function automatic logic bigChange(input logic [`LD_MEAS_W-1:0] r,
                                     input logic [`LD_MEAS_W-1:0] m);
    bigChange = absDiff(r, m) > (r >> 2);
  endfunction

  // Pins settle through two flops before any use
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
    end else begin
      syncA_reg <= {extResetPinN, supplyFailPin, loopOpenPin, loopShortPin,
                    sensSwitchPin, modeSwitchPin, freqSwitchPin};
      syncB_reg <= syncA_reg;
    end
  end

  assign extResetN = syncB_reg[21];
  assign supplyFail = syncB_reg[20];
  assign loopOpen = syncB_reg[19:18];
  assign loopShort = syncB_reg[17:16];
  assign switchNow = syncB_reg[15:0];
  assign sens[0] = syncB_reg[11:8];
  assign sens[1] = syncB_reg[15:12];
  assign mode[0] = syncB_reg[5:4];
  assign mode[1] = syncB_reg[7:6];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      switchPrev_reg <= 16'h0000;
    end else begin
      switchPrev_reg <= switchNow;
    end
  end

  assign fullReset = !rst_n || !extResetN || (switchNow != switchPrev_reg) || swReset_reg;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      loopFreqSel <= 4'h0;
    end else begin
      loopFreqSel <= switchNow[3:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (fullReset || tickCnt_reg == TICK_LAST) begin
      tickCnt_reg <= 17'h00000;
    end else begin
      tickCnt_reg <= tickCnt_reg + 17'h00001;
    end
  end

  assign msTick = (tickCnt_reg == TICK_LAST);

  // Slot ends on a sample or a timeout; an off channel is skipped
  always_ff @(posedge mclk) begin
    if (fullReset) begin
      scan_reg <= SCAN_CH0;
      slotMs_reg <= 12'h000;
    end else begin
      case (scan_reg)
        SCAN_CH0: begin
          if (sampleHit[0] || slotTimeout[0] || sens[0] == 4'h0) begin
            scan_reg <= (sens[1] != 4'h0) ? SCAN_CH1 : SCAN_CH0;
            slotMs_reg <= 12'h000;
          end else if (msTick) begin
            slotMs_reg <= slotMs_reg + 12'd1;
          end
        end
        SCAN_CH1: begin
          if (sampleHit[1] || slotTimeout[1] || sens[1] == 4'h0) begin
            scan_reg <= (sens[0] != 4'h0) ? SCAN_CH0 : SCAN_CH1;
            slotMs_reg <= 12'h000;
          end else if (msTick) begin
            slotMs_reg <= slotMs_reg + 12'd1;
          end
        end
        default: begin
          scan_reg <= SCAN_CH0;
          slotMs_reg <= 12'h000;
        end
      endcase
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      oscEnable[i] = !fullReset && scan_reg[i] && sens[i] != 4'h0;
      sampleHit[i] = oscEnable[i] && measValid;
      slotTimeout[i] = oscEnable[i] && !measValid && msTick && slotMs_reg >= `LD_SLOT_TIMEOUT_MS;
      faultActive[i] = chanState_reg[i] == CH_FAULT;
    end
  end

  // Channel state, reference and fault code in one place
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 2; i++) begin
      if (fullReset) begin
        chanState_reg[i] <= CH_OFF;
        ref_reg[i] <= '0;
        lastMeas_reg[i] <= '0;
        faultCode_reg[i] <= FAULT_NONE;
        holdMs_reg[i] <= 12'h000;
        trackMs_reg[i] <= 12'h000;
      end else begin
        if (sampleHit[i]) begin
          lastMeas_reg[i] <= measCount;
        end
        if (sens[i] == 4'h0) begin
          chanState_reg[i] <= CH_OFF;
          faultCode_reg[i] <= FAULT_NONE;
        end else begin
          case (chanState_reg[i])
            CH_OFF: begin
              chanState_reg[i] <= CH_TUNE;
            end
            CH_TUNE: begin
              if (sampleHit[i]) begin
                ref_reg[i] <= measCount;
                chanState_reg[i] <= CH_RUN;
              end
            end
            CH_RUN: begin
              holdMs_reg[i] <= 12'h000;
              if (loopOpen[i] || slotTimeout[i] || (sampleHit[i] && measCount == '0)) begin
                chanState_reg[i] <= CH_FAULT;
                faultCode_reg[i] <= FAULT_OPEN;
              end else if (loopShort[i]) begin
                chanState_reg[i] <= CH_FAULT;
                faultCode_reg[i] <= FAULT_SHORT;
              end else if (sampleHit[i] && bigChange(ref_reg[i], measCount)) begin
                chanState_reg[i] <= CH_FAULT;
                faultCode_reg[i] <= FAULT_CHANGE;
              end else if (rebase[i]) begin
                ref_reg[i] <= lastMeas_reg[i];
              end else if (!detLevel_reg[i] && msTick) begin
                if (trackMs_reg[i] == `LD_TRACK_MS - 12'd1) begin
                  trackMs_reg[i] <= 12'h000;
                  if (ref_reg[i] < lastMeas_reg[i]) begin
                    ref_reg[i] <= ref_reg[i] + 1'b1;
                  end else if (ref_reg[i] > lastMeas_reg[i]) begin
                    ref_reg[i] <= ref_reg[i] - 1'b1;
                  end
                end else begin
                  trackMs_reg[i] <= trackMs_reg[i] + 12'd1;
                end
              end
            end
            CH_FAULT: begin
              if (faultCode_reg[i] == FAULT_CHANGE) begin
                if (msTick) begin
                  holdMs_reg[i] <= holdMs_reg[i] + 12'd1;
                end
                if (holdMs_reg[i] >= `LD_CHANGE_HOLD_MS) begin
                  ref_reg[i] <= lastMeas_reg[i];
                  chanState_reg[i] <= CH_RUN;
                  faultCode_reg[i] <= FAULT_NONE;
                end
              end else if (sampleHit[i] && measCount != '0 && !loopOpen[i] && !loopShort[i]) begin
                chanState_reg[i] <= CH_RUN;
                faultCode_reg[i] <= FAULT_NONE;
              end
            end
            default: begin
              chanState_reg[i] <= CH_OFF;
            end
          endcase
        end
      end
    end
  end

  // Memory survives fault clearance; a new fault beats a software clear
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 2; i++) begin
      if (fullReset) begin
        faultMem_reg[i] <= FAULT_NONE;
      end else if (faultActive[i]) begin
        faultMem_reg[i] <= faultCode_reg[i];
      end else if (clrMem_reg) begin
        faultMem_reg[i] <= FAULT_NONE;
      end
    end
  end

  // Vehicle lowers the count; the drop must hold for the response time
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 2; i++) begin
      if (fullReset || chanState_reg[i] != CH_RUN || rebase[i]) begin
        detLevel_reg[i] <= 1'b0;
        confirmMs_reg[i] <= 12'h000;
        callLevel_reg[i] <= 1'b0;
      end else begin
        if (sampleHit[i]) begin
          detLevel_reg[i] <= (ref_reg[i] > measCount) &&
                             (ref_reg[i] - measCount > threshold(ref_reg[i], sens[i]));
        end
        if (!detLevel_reg[i]) begin
          confirmMs_reg[i] <= 12'h000;
          callLevel_reg[i] <= 1'b0;
        end else if (confirmMs_reg[i] >= respMs(sens[i])) begin
          callLevel_reg[i] <= 1'b1;
        end else if (msTick) begin
          confirmMs_reg[i] <= confirmMs_reg[i] + 12'd1;
        end
      end
    end
  end

  // Pulse mode is mode code 2; other codes are presence
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 2; i++) begin
      if (fullReset) begin
        callPrev_reg[i] <= 1'b0;
        pulseMs_reg[i] <= 12'h000;
        inhibitMs_reg[i] <= 12'h000;
      end else begin
        callPrev_reg[i] <= callLevel_reg[i];
        if (callLevel_reg[i] && !callPrev_reg[i]) begin
          pulseMs_reg[i] <= `LD_CALL_PULSE_MS;
        end else if (msTick && pulseMs_reg[i] != 12'h000) begin
          pulseMs_reg[i] <= pulseMs_reg[i] - 12'd1;
        end
        if (!callLevel_reg[i] || mode[i] != 2'h2) begin
          inhibitMs_reg[i] <= 12'h000;
        end else if (msTick) begin
          inhibitMs_reg[i] <= inhibitMs_reg[i] + 12'd1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      rebase[i] = inhibitMs_reg[i] >= `LD_PULSE_INHIBIT_MS;
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < 2; i++) begin
      if (fullReset || chanState_reg[i] == CH_OFF) begin
        callOut[i] <= 1'b0;
      end else if (faultActive[i]) begin
        callOut[i] <= 1'b1;
      end else if (mode[i] == 2'h2) begin
        callOut[i] <= pulseMs_reg[i] != 12'h000;
      end else begin
        callOut[i] <= callLevel_reg[i];
      end
    end
  end

  for (genvar g = 0; g < 2; g++) begin : gInd
    loop_indicator uInd (
      .mclk(mclk),
      .rst_n(rst_n),
      .restart(fullReset),
      .msTick(msTick),
      .faultActive(faultActive[g]),
      .faultCode(faultCode_reg[g]),
      .faultMem(faultMem_reg[g]),
      .callIn(callOut[g]),
      .failIn(supplyFail),
      .detectLamp(vehicleDetectLamp[g]),
      .faultLamp(loopFaultLamp[g]),
      .statusOut(statusOut[g])
    );
  end

  // Classic single-cycle slave: ack one cycle after the strobe
  logic wbHit;
  assign wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wbHit;
      if (wbHit && !wb_we_i) begin
        case (wb_adr_i)
          `LD_OFF_STATUS: begin
            wb_dat_o <= {18'h00000,
                         chanState_reg[1] != CH_OFF && chanState_reg[1] != CH_TUNE,
                         chanState_reg[0] != CH_OFF && chanState_reg[0] != CH_TUNE,
                         faultMem_reg[1], faultMem_reg[0], faultCode_reg[1],
                         faultCode_reg[0], faultActive, callOut};
          end
          `LD_OFF_REF0: wb_dat_o <= {16'h0000, ref_reg[0]};
          `LD_OFF_REF1: wb_dat_o <= {16'h0000, ref_reg[1]};
          `LD_OFF_SWITCH: wb_dat_o <= {16'h0000, switchNow};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // Control bits are self-clearing strobes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      {clrMem_reg, swReset_reg} <= `LD_CTRL_RESET;
    end else begin
      swReset_reg <= wbHit && wb_we_i && wb_sel_i[0] && wb_adr_i == `LD_OFF_CTRL &&
                     wb_dat_i[`LD_CTRL_SWRST_BIT];
      clrMem_reg <= wbHit && wb_we_i && wb_sel_i[0] && wb_adr_i == `LD_OFF_CTRL &&
                    wb_dat_i[`LD_CTRL_CLRMEM_BIT];
    end
  end
endmodule

// ===== rtl/loop_detector_regs.svh
// Constants for the two-channel loop detector: offsets, fields, resets, timing.
// Assumes a 100 MHz mclk; all slow timing counts run on a 1 ms tick.
`ifndef LOOP_DETECTOR_REGS_SVH
`define LOOP_DETECTOR_REGS_SVH

`define LD_CLK_PERIOD_NS 10
`define LD_TICK_NS 1000000
`define LD_MEAS_W 16

`define LD_OFF_CTRL 8'h00
`define LD_OFF_STATUS 8'h04
`define LD_OFF_REF0 8'h08
`define LD_OFF_REF1 8'h0C
`define LD_OFF_SWITCH 8'h10

`define LD_CTRL_SWRST_BIT 0
`define LD_CTRL_CLRMEM_BIT 1
`define LD_CTRL_RESET 2'h0

`define LD_ST_CALL_LSB 0
`define LD_ST_FAULT_LSB 2
`define LD_ST_CODE0_LSB 4
`define LD_ST_CODE1_LSB 6
`define LD_ST_MEM0_LSB 8
`define LD_ST_MEM1_LSB 10
`define LD_ST_TUNED_LSB 12

`define LD_SLOT_TIMEOUT_MS 12'd10
`define LD_CHANGE_HOLD_MS 12'd2000
`define LD_PULSE_INHIBIT_MS 12'd2000
`define LD_CALL_PULSE_MS 12'd125
`define LD_TRACK_MS 12'd64
`define LD_STATUS_ON_MS 12'd50
`define LD_STATUS_UNIT_MS 12'd50
`define LD_FLASH_FRAME_MS 12'd1000
`define LD_FLASH_SLOT_MS 12'd200
`define LD_FLASH_ON_MS 12'd100

`endif

// ===== rtl/loop_detector_pkg.sv
// Types shared by the loop detector top and its indicator module.
// Assumes the constants header is included by each user.
package loop_detector_pkg;
  // Code value equals the flash count of the fault
  typedef enum logic [1:0] {
    FAULT_NONE = 2'h0,
    FAULT_OPEN = 2'h1,
    FAULT_SHORT = 2'h2,
    FAULT_CHANGE = 2'h3
  } fault_t;

  typedef enum logic [1:0] {
    SCAN_CH0 = 2'b01,
    SCAN_CH1 = 2'b10
  } scan_state_t;

  typedef enum logic [3:0] {
    CH_OFF = 4'b0001,
    CH_TUNE = 4'b0010,
    CH_RUN = 4'b0100,
    CH_FAULT = 4'b1000
  } chan_state_t;
endpackage

// ===== rtl/loop_indicator.sv
// Per-channel lamps and status pulse output.
// Assumes a 1 ms tick pulse and a synchronous restart from the top.
`timescale 1ns/1ps
`include "loop_detector_regs.svh"
module loop_indicator (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic msTick,
  input wire logic faultActive,
  input wire loop_detector_pkg::fault_t faultCode,
  input wire loop_detector_pkg::fault_t faultMem,
  input wire logic callIn,
  input wire logic failIn,
  output logic detectLamp,
  output logic faultLamp,
  output logic statusOut
);
  import loop_detector_pkg::*;

  logic [11:0] frameMs_reg;
  logic [11:0] pulseMs_reg;
  fault_t lastCode_reg;

  function automatic logic flashOn(input logic [11:0] ms, input fault_t code);
    logic [11:0] slot;
    slot = ms % `LD_FLASH_SLOT_MS;
    flashOn = (ms < (`LD_FLASH_SLOT_MS * {10'h000, code})) && (slot < `LD_FLASH_ON_MS);
  endfunction

  always_ff @(posedge mclk) begin
    if (!rst_n || restart) begin
      frameMs_reg <= 12'h000;
    end else if (msTick) begin
      frameMs_reg <= (frameMs_reg == `LD_FLASH_FRAME_MS - 12'd1) ? 12'h000 : frameMs_reg + 12'd1;
    end
  end

  // Pulse train restarts on a new code so the first off pulse is whole
  always_ff @(posedge mclk) begin
    if (!rst_n || restart || faultCode != lastCode_reg) begin
      pulseMs_reg <= 12'h000;
    end else if (msTick) begin
      if (pulseMs_reg == `LD_STATUS_UNIT_MS * {10'h000, faultCode} + `LD_STATUS_ON_MS - 12'd1) begin
        pulseMs_reg <= 12'h000;
      end else begin
        pulseMs_reg <= pulseMs_reg + 12'd1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || restart) begin
      lastCode_reg <= FAULT_NONE;
    end else begin
      lastCode_reg <= faultCode;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || restart) begin
      detectLamp <= 1'b0;
      faultLamp <= 1'b0;
    end else begin
      detectLamp <= faultActive ? flashOn(frameMs_reg, faultCode) : callIn;
      faultLamp <= flashOn(frameMs_reg, faultMem);
    end
  end

  // Low means on; high is the safe idle during reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      statusOut <= 1'b1;
    end else if (failIn) begin
      statusOut <= 1'b1;
    end else if (!faultActive || faultCode == FAULT_NONE) begin
      statusOut <= 1'b0;
    end else begin
      statusOut <= pulseMs_reg < `LD_STATUS_UNIT_MS * {10'h000, faultCode};
    end
  end
endmodule

// ===== bench/loop_detector_channel_status_chk.sv
// Port checker for the loop detector top.
// Assumes TICK_CYCLES mclk cycles make one ms.
`timescale 1ns/1ps
module loop_detector_channel_status_chk #(
  parameter int TICK_CYCLES = 100000
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic supplyFailPin,
  input wire logic [7:0] sensSwitchPin,
  input wire logic [1:0] oscEnable,
  input wire logic [1:0] callOut,
  input wire logic [1:0] vehicleDetectLamp,
  input wire logic [1:0] statusOut
);
  localparam int T = TICK_CYCLES;
  int hiCnt;
  int loCnt;
  always_ff @(posedge mclk) begin
    if (!rst_n || !statusOut[1]) hiCnt <= 0;
    else hiCnt <= hiCnt + 1;
  end
  always_ff @(posedge mclk) begin
    if (!rst_n || statusOut[1]) loCnt <= 0;
    else loCnt <= loCnt + 1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  property p_ack;
    s_req |=> wb_ack_o;
  endproperty
  property p_ackone;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_oneosc;
    $onehot0(oscEnable);
  endproperty
  property p_sensoff;
    (sensSwitchPin[7:4] == 4'h0) [*8] |-> !oscEnable[1] && !callOut[1];
  endproperty
  property p_supply;
    supplyFailPin [*5] |-> statusOut == 2'h3;
  endproperty
  property p_lamp;
    (~callOut & ~$past(callOut) & vehicleDetectLamp) == 2'h0;
  endproperty
  // Short runs are resets, long ones supply failure
  property p_offw;
    $fell(statusOut[1]) && hiCnt > 20 * T && hiCnt < 170 * T
      |-> ((hiCnt + 10 * T) % (50 * T)) <= 20 * T;
  endproperty
  property p_onw;
    $rose(statusOut[1]) && loCnt > 20 * T && loCnt < 100 * T |-> loCnt inside {[40 * T:60 * T]};
  endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  a_ackone: assert property (p_ackone) else $error("ack too long");
  a_oneosc: assert property (p_oneosc) else $error("two loops energized");
  a_sensoff: assert property (p_sensoff) else $error("channel not off");
  a_supply: assert property (p_supply) else $error("status not off");
  a_lamp: assert property (p_lamp) else $error("detect lamp without call");
  a_offw: assert property (p_offw) else $error("status off width");
  a_onw: assert property (p_onw) else $error("status on width");
endmodule

bind loop_detector_channel_status loop_detector_channel_status_chk #(
  .TICK_CYCLES(TICK_CYCLES)) i_chk (.mclk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .supplyFailPin, .sensSwitchPin, .oscEnable, .callOut, .vehicleDetectLamp, .statusOut);

// ===== bench/loop_model.sv
// Loop oscillator model: one sample per energized slot, after a random delay.
// Assumes the design advances its scan after each sample.
`timescale 1ns/1ps
module loop_model (
  input wire logic mclk,
  input wire logic [1:0] oscEnable,
  input wire logic [15:0] meas0,
  input wire logic [15:0] meas1,
  output logic [15:0] measCount,
  output logic measValid
);
  logic [1:0] lastEn = 2'h0;
  int dly = 3;
  wire fire = dly == 0 && oscEnable == lastEn && !measValid && oscEnable != 2'h0;
  initial measCount = 16'h0;
  initial measValid = 1'b0;
  always @(posedge mclk) begin
    lastEn <= oscEnable;
    measValid <= fire;
    // Idle count toggles; stale samples never look valid
    if (fire) measCount <= oscEnable[0] ? meas0 : meas1;
    else measCount <= ~measCount;
    if (oscEnable != lastEn || measValid) dly <= 2 + $urandom % 8;
    else if (dly > 0) dly <= dly - 1;
  end
endmodule

// ===== bench/loop_detector_channel_status_tb.sv
// Self-checking bench for the loop detector top.
// Assumes TICK_CYCLES shrunk to TC cycles per ms.
`timescale 1ns/1ps
`include "loop_detector_regs.svh"
module loop_detector_channel_status_tb;
  localparam int TC = 10;
  logic mclk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, extResetPinN, supplyFailPin;
  logic measValid;
  logic [7:0] wb_adr_i, sensSwitchPin;
  logic [3:0] wb_sel_i, modeSwitchPin, freqSwitchPin, loopFreqSel;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [1:0] loopOpenPin, loopShortPin, oscEnable, callOut, vehicleDetectLamp;
  logic [1:0] loopFaultLamp, statusOut;
  logic [15:0] measCount, meas0, meas1, m0, m1;
  int miscompares, num_checks, n, a, b, s0;
  loop_detector_channel_status #(.TICK_CYCLES(TC)) i_dut (.mclk, .rst_n, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .extResetPinN,
    .supplyFailPin, .loopOpenPin, .loopShortPin, .sensSwitchPin, .modeSwitchPin,
    .freqSwitchPin, .measCount, .measValid, .oscEnable, .loopFreqSel, .callOut,
    .vehicleDetectLamp, .loopFaultLamp, .statusOut);
  loop_model i_loop (.mclk, .oscEnable, .meas0, .meas1, .measCount, .measValid);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic close_out();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
  endtask
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d,
      output logic [31:0] r);
    int t = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= ad;
    wb_dat_i <= d;
    do begin
      @(posedge mclk);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (t >= 50) begin
      miscompares++;
      close_out();
    end
    @(posedge mclk);
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return statusOut[1];
      1: return callOut[0];
      2: return loopFaultLamp[1];
      default: return vehicleDetectLamp[1];
    endcase
  endfunction
  task automatic waitFor(input int k, input logic v, input int lim);
    int t = 0;
    while (pick(k) !== v) begin
      @(posedge mclk);
      t++;
      if (t > lim) begin
        miscompares++;
        close_out();
      end
    end
  endtask
  task automatic runLen(input int k, output int r);
    waitFor(k, 1'b0, 300 * TC);
    waitFor(k, 1'b1, 300 * TC);
    r = 0;
    while (pick(k) === 1'b1 && r < 300 * TC) begin
      @(posedge mclk);
      r++;
    end
  endtask
  // Rising edges of two neighbours
  task automatic rises(input int k, input int c, output int ra, output int rb);
    logic pa, pb;
    ra = 0;
    rb = 0;
    pa = pick(k);
    pb = pick(k + 1);
    repeat (c) begin
      @(posedge mclk);
      if (pick(k) === 1'b1 && pa !== 1'b1) ra++;
      if (pick(k + 1) === 1'b1 && pb !== 1'b1) rb++;
      pa = pick(k);
      pb = pick(k + 1);
    end
  endtask
  // Fastest response, ms
  function automatic int resp(input int s);
    int t[16] = '{0, 4, 4, 4, 4, 4, 5, 5, 7, 9, 13, 18, 26, 38, 57, 76};
    return t[s];
  endfunction
  initial begin
    void'($urandom(47417));
    s0 = 1 + $urandom % 15;
    m0 = 16'h2000 + 16'($urandom % 16384);
    m1 = 16'h2000 + 16'($urandom % 16384);
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, supplyFailPin} = 5'h0;
    {wb_adr_i, wb_dat_i, loopOpenPin, loopShortPin, modeSwitchPin} = '0;
    wb_sel_i = 4'hF;
    extResetPinN = 1'b1;
    sensSwitchPin = {4'h7, 4'(s0)};
    freqSwitchPin = 4'($urandom % 16);
    meas0 = m0;
    meas1 = m1;
    tick(12);
    rst_n <= 1'b1;
    tick(150);
    wb(1'b0, `LD_OFF_STATUS, 32'h0, q);
    chk(q, 32'h3000);
    wb(1'b0, `LD_OFF_REF0, 32'h0, q);
    chk(q, {16'h0, m0});
    wb(1'b0, `LD_OFF_REF1, 32'h0, q);
    chk(q, {16'h0, m1});
    wb(1'b0, 8'h14, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b0, `LD_OFF_SWITCH, 32'h0, q);
    chk(q, {16'h0, sensSwitchPin, modeSwitchPin, freqSwitchPin});
    chk(loopFreqSel, freqSwitchPin);
    chk(statusOut, 2'h0);
    meas0 <= m0 - (m0 >> 4);
    tick((resp(s0) - 2) * TC);
    chk(callOut[0], 1'b0);
    waitFor(1, 1'b1, 200 * TC);
    tick(2);
    chk(vehicleDetectLamp[0], 1'b1);
    meas0 <= m0;
    waitFor(1, 1'b0, 200 * TC);
    m0 = m0 + 16'h3;
    meas0 <= m0;
    tick(260 * TC + 200);
    wb(1'b0, `LD_OFF_REF0, 32'h0, q);
    chk(q, {16'h0, m0});
    for (int j = 0; j < 2; j++) begin
      m0 = m0 + 16'h28;
      meas0 <= m0;
      tick(3);
      if (j == 0) extResetPinN <= 1'b0;
      else freqSwitchPin <= freqSwitchPin ^ 4'h1;
      tick(5);
      extResetPinN <= 1'b1;
      tick(100);
      wb(1'b0, `LD_OFF_REF0, 32'h0, q);
      chk(q, {16'h0, m0});
    end
    for (int k = 1; k <= 3; k++) begin
      if (k == 1) loopOpenPin <= 2'h2;
      if (k == 2) loopShortPin <= 2'h2;
      if (k == 3) meas1 <= m1 + (m1 >> 1);
      tick(300);
      wb(1'b0, `LD_OFF_STATUS, 32'h0, q);
      chk({q[7:6], q[3], q[1]}, {k[1:0], 2'h3});
      runLen(0, n);
      chk(n > (k * 50 - 10) * TC && n < (k * 50 + 10) * TC, 1'b1);
      rises(2, 1000 * TC, a, b);
      chk(a, k);
      chk(b, k);
      waitFor(0, 1'b1, 300 * TC);
      waitFor(0, 1'b0, 300 * TC);
      loopOpenPin <= 2'h0;
      loopShortPin <= 2'h0;
      tick(k == 3 ? 2100 * TC : 100 * TC);
      if (k == 3) begin
        m1 = m1 + (m1 >> 1);
        wb(1'b0, `LD_OFF_REF1, 32'h0, q);
        chk(q, {16'h0, m1});
      end
      wb(1'b0, `LD_OFF_STATUS, 32'h0, q);
      chk({q[11:10], q[7:6], q[3], q[1]}, {k[1:0], 4'h0});
    end
    wb(1'b1, `LD_OFF_CTRL, 32'h2, q);
    wb(1'b0, `LD_OFF_STATUS, 32'h0, q);
    chk(q[11:8], 4'h0);
    modeSwitchPin <= 4'h2;
    tick(150);
    meas0 <= m0 - (m0 >> 4);
    runLen(1, n);
    chk(n >= 100 * TC && n <= 150 * TC, 1'b1);
    rises(1, 1900 * TC, a, b);
    chk(a, 0);
    tick(200 * TC);
    meas0 <= m0 - (m0 >> 3);
    waitFor(1, 1'b1, 200 * TC);
    supplyFailPin <= 1'b1;
    tick(10);
    chk(statusOut, 2'h3);
    supplyFailPin <= 1'b0;
    sensSwitchPin <= {4'h0, 4'(s0)};
    tick(50);
    chk({oscEnable[1], callOut[1]}, 2'h0);
    close_out();
  end
endmodule
